// ===== core/wdt_core.v
// watchdog timer with reload bytes, time-out response and apb registers
`timescale 1ns/1ps
`default_nettype none
`include "wdt_regs.vh"

module wdt_core #(
  parameter DIV_W = 8,
  parameter [DIV_W-1:0] COUNT_DIV = 8'h01
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [13:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  // cpu core side
  input wire refresh_pulse,
  input wire stop_mode,
  // nonvolatile option bit, 1 selects reset response
  input wire timeout_response_select,
  // interrupt controller and reset side
  output reg wdt_irq_req,
  output reg stop_recovery_start,
  output reg wdt_system_reset,
  output wire irq
);

  ////////////////////////////////////////////////////////////////////////
  // declarations
  localparam [2:0] ST_OFF = 3'b001;
  localparam [2:0] ST_RUN = 3'b010;
  localparam [2:0] ST_HOLD = 3'b100;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [7:0] reload_upper_byte;
  reg [7:0] reload_middle_byte;
  reg [7:0] reload_low_byte;
  reg [23:0] count;
  reg [DIV_W-1:0] div_cnt;
  reg ctrl_enable;
  reg ctrl_stop;
  reg cause_wdt;
  reg [`WDT_EV_W-1:0] irq_stat;
  reg [`WDT_EV_W-1:0] irq_en;
  reg resp_meta;
  reg resp_sync;
  wire [11:0] idx;
  wire setup;
  wire access;
  wire wr;
  wire rd;
  wire wr_lane0;
  wire [23:0] reload_value;
  wire tick;
  wire timeout;
  wire to_irq;
  wire to_stop;
  wire [`WDT_EV_W-1:0] ev;
  wire [`WDT_EV_W-1:0] clr;

  ////////////////////////////////////////////////////////////////////////
  // functions
  function mapped;
    input [11:0] i;
    begin
      mapped = (i >= `WDT_IDX_CAUSE) && (i <= `WDT_IDX_IRQ_CLR);
    end
  endfunction

  function [7:0] count_byte;
    input [23:0] c;
    input [1:0] sel;
    begin
      case (sel)
        2'd2: count_byte = c[23:16];
        2'd1: count_byte = c[15:8];
        default: count_byte = c[7:0];
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // apb decode
  assign idx = paddr[13:2];
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign wr = access & pwrite;
  assign rd = access & ~pwrite;
  assign wr_lane0 = wr & pstrb[0];
  // zero wait states; read data is captured in the setup cycle
  assign pready = 1'b1;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= ~mapped(idx);
      prdata <= 32'h0000_0000;
      case (idx)
        `WDT_IDX_CAUSE: prdata[`WDT_CAUSE_WDT_BIT] <= cause_wdt;
        `WDT_IDX_UPPER: prdata[7:0] <= count_byte(count, 2'd2);
        `WDT_IDX_MIDDLE: prdata[7:0] <= count_byte(count, 2'd1);
        `WDT_IDX_LOW: prdata[7:0] <= count_byte(count, 2'd0);
        `WDT_IDX_CTRL: begin
          prdata[`WDT_CTRL_EN_BIT] <= ctrl_enable;
          prdata[`WDT_CTRL_STOP_BIT] <= ctrl_stop;
          prdata[`WDT_CTRL_RESP_BIT] <= resp_sync;
        end
        `WDT_IDX_IRQ_STAT: prdata[`WDT_EV_W-1:0] <= irq_stat;
        `WDT_IDX_IRQ_EN: prdata[`WDT_EV_W-1:0] <= irq_en;
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // option bit synchroniser
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp_meta <= 1'b0;
      resp_sync <= 1'b0;
    end else begin
      resp_meta <= timeout_response_select;
      resp_sync <= resp_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reload bytes and control
  // nothing stops a reload below 4; software owns that limit
  assign reload_value = {reload_upper_byte, reload_middle_byte, reload_low_byte};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_upper_byte <= `WDT_RST_UPPER;
      reload_middle_byte <= `WDT_RST_MIDDLE;
      reload_low_byte <= `WDT_RST_LOW;
      ctrl_enable <= 1'b0;
      irq_en <= {`WDT_EV_W{1'b0}};
    end else if (wr_lane0) begin
      case (idx)
        `WDT_IDX_UPPER: reload_upper_byte <= pwdata[7:0];
        `WDT_IDX_MIDDLE: reload_middle_byte <= pwdata[7:0];
        `WDT_IDX_LOW: reload_low_byte <= pwdata[7:0];
        `WDT_IDX_CTRL: ctrl_enable <= pwdata[`WDT_CTRL_EN_BIT];
        `WDT_IDX_IRQ_EN: irq_en <= pwdata[`WDT_EV_W-1:0];
        default: ctrl_enable <= ctrl_enable;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // count period
  assign tick = (div_cnt == COUNT_DIV - 1'b1);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= {DIV_W{1'b0}};
    end else if (state != ST_RUN || tick) begin
      div_cnt <= {DIV_W{1'b0}};
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state machine
  assign timeout = (state == ST_RUN) && (count == `WDT_COUNT_ZERO);
  assign to_irq = timeout & ~resp_sync;
  assign to_stop = to_irq & stop_mode;

  always @* begin
    next_state = state;
    case (state)
      ST_OFF: begin
        // a refresh also starts a stopped watchdog
        if (ctrl_enable || refresh_pulse) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (timeout && resp_sync) begin
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: next_state = ST_HOLD;
      default: next_state = ST_OFF;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // down-counter
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= `WDT_COUNT_ZERO;
    end else if (state == ST_OFF) begin
      if (next_state == ST_RUN) begin
        count <= reload_value;
      end
    end else if (to_irq) begin
      // an interrupt time-out wins over a refresh in the same cycle
      count <= `WDT_COUNT_AFTER_IRQ;
    end else if (state == ST_RUN && refresh_pulse) begin
      count <= reload_value;
    // a count at zero never wraps round; an interrupt time-out moves it away, a reset time-out leaves it at zero unless a refresh in that cycle reloads it
    end else if (state == ST_RUN && tick && count != `WDT_COUNT_ZERO) begin
      count <= count - `WDT_COUNT_ONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // time-out responses
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_irq_req <= 1'b0;
      stop_recovery_start <= 1'b0;
      wdt_system_reset <= 1'b0;
    end else begin
      // one-cycle request; the controller latches it across recovery
      wdt_irq_req <= to_irq;
      stop_recovery_start <= to_stop;
      if (timeout && resp_sync) begin
        wdt_system_reset <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // flags: a set in the same cycle as its clear wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_wdt <= 1'b0;
      ctrl_stop <= 1'b0;
    end else begin
      // a read clears only a flag that it returned; a set in the setup cycle survives
      if (timeout) begin
        cause_wdt <= 1'b1;
      end else if (rd && idx == `WDT_IDX_CAUSE && prdata[`WDT_CAUSE_WDT_BIT]) begin
        cause_wdt <= 1'b0;
      end
      // any stop-mode time-out marks the stop bit, whatever the response
      if (timeout && stop_mode) begin
        ctrl_stop <= 1'b1;
      end else if (rd && idx == `WDT_IDX_CTRL && prdata[`WDT_CTRL_STOP_BIT]) begin
        ctrl_stop <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt status, enable and write-one clear
  assign ev = {to_stop, to_irq};
  assign clr = (wr_lane0 && idx == `WDT_IDX_IRQ_CLR) ? pwdata[`WDT_EV_W-1:0] : {`WDT_EV_W{1'b0}};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= {`WDT_EV_W{1'b0}};
    end else begin
      irq_stat <= (irq_stat & ~clr) | ev;
    end
  end

  assign irq = |(irq_stat & irq_en);

endmodule // wdt_core
`default_nettype wire

// ===== core/wdt_regs.vh
// register indices, field positions, reset values and counts for the watchdog
`ifndef WDT_REGS_VH
`define WDT_REGS_VH
// register indices; byte address is four times the index
`define WDT_IDX_CAUSE 12'hff0
`define WDT_IDX_UPPER 12'hff1
`define WDT_IDX_MIDDLE 12'hff2
`define WDT_IDX_LOW 12'hff3
`define WDT_IDX_CTRL 12'hff4
`define WDT_IDX_IRQ_STAT 12'hff5
`define WDT_IDX_IRQ_EN 12'hff6
`define WDT_IDX_IRQ_CLR 12'hff7
// reset values of the reload bytes
`define WDT_RST_UPPER 8'h00
`define WDT_RST_MIDDLE 8'h04
`define WDT_RST_LOW 8'h00
// reset cause register fields
`define WDT_CAUSE_WDT_BIT 5
// control register fields
`define WDT_CTRL_EN_BIT 0
`define WDT_CTRL_STOP_BIT 1
`define WDT_CTRL_RESP_BIT 2
// interrupt status, enable and clear fields
`define WDT_EV_TIMEOUT_BIT 0
`define WDT_EV_STOPREC_BIT 1
`define WDT_EV_W 2
// counter values
`define WDT_COUNT_ZERO 24'h00_0000
`define WDT_COUNT_AFTER_IRQ 24'h0f_ffff
`define WDT_COUNT_ONE 24'h00_0001
`endif

// ===== testbench/testbench.sv
// self-checking bench for the watchdog block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct {logic w; logic [11:0] ix; logic [7:0] d; logic [7:0] e; logic er;} wdt_row_t;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, tsel = 0, ka = 0, sreq = 0, err;
  logic [13:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, rfr, stm, irqr, srs, sysr, irq;
  int bad_count = 0, n_tests = 0, cyc = 0, since = 0, nirq = 0, vc, n, k;
  wdt_row_t rows [10];
  wdt_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .refresh_pulse(rfr), .stop_mode(stm), .timeout_response_select(tsel), .wdt_irq_req(irqr),
    .stop_recovery_start(srs), .wdt_system_reset(sysr), .irq(irq));
  wdt_cpu i_cpu (.pclk(pclk), .presetn(presetn), .keep_alive(ka), .stop_req(sreq), .wdt_irq_req(irqr),
    .stop_recovery_start(srs), .refresh_pulse(rfr), .stop_mode(stm), .vec_count(vc));
  always #2 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    since <= rfr ? 0 : since + 1;
    if (irqr) nirq <= nirq + 1;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      test_done;
    end
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] ix, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= {ix, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    #1;
  endtask
  // stops on either response so a wrong response mode cannot hang the run
  task automatic wto(input int lim);
    n = 0;
    while (irqr !== 1'b1 && sysr !== 1'b1 && n < lim) begin
      @(posedge pclk) #1;
      n++;
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    rows = '{'{1, 12'hff3, 8'h06, 0, 0}, '{1, 12'hff2, 0, 0, 0}, '{1, 12'hff1, 0, 0, 0},
      '{0, 12'hff1, 0, 0, 0}, '{0, 12'hff0, 0, 0, 0}, '{0, 12'hff4, 0, 0, 0}, '{1, 12'hff6, 1, 0, 0},
      '{0, 12'hff6, 0, 1, 0}, '{0, 12'hfef, 0, 0, 1}, '{1, 12'hff8, 5, 0, 1}};
    repeat (12) @(posedge pclk);
    presetn <= 1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].ix, rows[i].d);
      chk("err", err, rows[i].er);
      if (!rows[i].w) chk("data", rd, rows[i].e);
    end
    $display("table done");
    apb(1, 12'hff4, 8'h01);
    wto(20);
    chk("first", n, 8);
    apb(0, 12'hff1, 0);
    chk("upper", rd, 32'h0000_000f);
    apb(0, 12'hff0, 0);
    chk("cause", rd, 32'h0000_0020);
    apb(0, 12'hff0, 0);
    chk("cause2", rd, 0);
    chk("irq", irq, 1);
    apb(1, 12'hff7, 8'h01);
    chk("irqclr", irq, 0);
    chk("vec", vc, 1);
    $display("interrupt done");
    apb(1, 12'hff2, 8'h01);
    apb(1, 12'hff3, 8'h05);
    @(posedge pclk);
    ka <= 1;
    k = nirq;
    repeat (8) @(posedge pclk);
    apb(0, 12'hff2, 0);
    chk("mid", rd, 1);
    apb(0, 12'hff1, 0);
    chk("up", rd, 0);
    apb(0, 12'hff3, 0);
    chk("low", rd[7:4], 0);
    chk("kept", nirq, k);
    @(posedge pclk);
    ka <= 0;
    wto(300);
    chk("reload", since, 32'h0000_0106);
    $display("refresh done");
    apb(0, 12'hff0, 0);
    chk("cause4", rd, 32'h0000_0020);
    apb(1, 12'hff7, 8'h03);
    @(posedge pclk);
    ka <= 1;
    repeat (6) @(posedge pclk);
    ka <= 0;
    sreq <= 1;
    @(posedge pclk);
    sreq <= 0;
    wto(300);
    chk("srs", srs, 1);
    apb(0, 12'hff4, 0);
    chk("ctrl", rd, 32'h0000_0003);
    apb(0, 12'hff0, 0);
    chk("cause3", rd, 32'h0000_0020);
    apb(0, 12'hff5, 0);
    chk("stat", rd, 32'h0000_0003);
    chk("vec3", vc, 3);
    $display("stop done");
    @(posedge pclk);
    tsel <= 1;
    presetn <= 0;
    repeat (12) @(posedge pclk);
    chk("rstirq", irq, 0);
    presetn <= 1;
    apb(1, 12'hff3, 8'h04);
    apb(1, 12'hff2, 8'h00);
    apb(0, 12'hff4, 0);
    chk("opt", rd, 32'h0000_0004);
    apb(1, 12'hff4, 8'h01);
    k = nirq;
    wto(20);
    chk("rst", sysr, 1);
    chk("rstcyc", n, 6);
    chk("noirq", nirq, k);
    $display("reset done");
    test_done;
  end
endmodule // testbench
`default_nettype wire

// ===== testbench/wdt_asserts.sv
// assertions on the watchdog ports
`timescale 1ns/1ps
`default_nettype none
module wdt_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic stop_mode,
  input wire logic wdt_irq_req,
  input wire logic stop_recovery_start,
  input wire logic wdt_system_reset
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_map_err: assert property (psel && penable |-> pslverr == (paddr[13:5] != 9'h1fe))
    else $error("slave error wrong");
  a_read_width: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h00_0000)
    else $error("read data too wide");
  // assumes software keeps the reload at least 4, so a new request needs more than five cycles
  a_irq_pulse: assert property (wdt_irq_req |=> !wdt_irq_req [*5])
    else $error("time-out request repeats");
  a_stop_irq: assert property (stop_recovery_start |-> wdt_irq_req)
    else $error("stop recovery without request");
  a_stop_cause: assert property (stop_recovery_start |-> $past(stop_mode))
    else $error("stop recovery outside stop");
  a_stop_pulse: assert property (stop_recovery_start |=> !stop_recovery_start)
    else $error("stop recovery not a pulse");
  a_reset_hold: assert property (wdt_system_reset |=> wdt_system_reset)
    else $error("system reset dropped");
  a_reset_only: assert property (wdt_system_reset |-> !wdt_irq_req)
    else $error("both responses at once");
  c_irq: cover property (wdt_irq_req);
  c_stop: cover property (stop_recovery_start);
  c_rst: cover property ($rose(wdt_system_reset));
endmodule // wdt_chk
bind wdt_core wdt_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .stop_mode(stop_mode), .wdt_irq_req(wdt_irq_req),
  .stop_recovery_start(stop_recovery_start), .wdt_system_reset(wdt_system_reset));
`default_nettype wire

// ===== testbench/wdt_cpu.sv
// model of the cpu core and interrupt controller
`timescale 1ns/1ps
`default_nettype none
module wdt_cpu (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic keep_alive,
  input wire logic stop_req,
  input wire logic wdt_irq_req,
  input wire logic stop_recovery_start,
  output logic refresh_pulse,
  output logic stop_mode,
  output int vec_count
);
  logic [1:0] gap;
  logic pend;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap <= 2'h0;
      pend <= 1'b0;
      refresh_pulse <= 1'b0;
      stop_mode <= 1'b0;
      vec_count <= 0;
    end else begin
      gap <= gap + 2'h1;
      refresh_pulse <= keep_alive && gap == 2'h0;
      if (stop_recovery_start) stop_mode <= 1'b0;
      else if (stop_req) stop_mode <= 1'b1;
      // the vector is fetched only once the core is awake again
      if (pend && !stop_mode) begin
        vec_count <= vec_count + 1;
        pend <= 1'b0;
      end else if (wdt_irq_req) pend <= 1'b1;
    end
  end
endmodule // wdt_cpu
`default_nettype wire
